// file: design/svsel_top.sv
// Source voltage selector: boot source choice, button-driven capability list,
// converter level selects, bypass enable, dual-path control and register readback.
// Assumes the PD protocol engine outside sends the messages this block pulses for.
//
// Notes on behaviour
// R1 - After reset only the 5 V capability is offered.
// R2 - 9 V button loads capabilities 5 V and 9 V.
// R3 - 15 V button loads capabilities 5, 9 and 15 V.
// R4 - 20 V button loads all four levels.
// R5 - A changed capability list triggers a fresh source capabilities message.
// R6 - 5 V button after a higher choice restores 5 V only.
// R7 - 9, 15, 20 V buttons are event inputs on general inputs 1, 2, 5.
// R8 - General outputs 15, 17, 20 drive the converter level selects.
// R9 - Pins 18 and 19 do charger detection and advertisement on D+/D-; the code does no detection, it only echoes D+ onto D-.
// R10 - Flash image is fetched only at boot after power-on reset.
// R11 - Boot may instead take a default configuration from the two straps.
// R12 - Boot may instead accept the image from an external controller.
// R13 - A 20 V contract enables the external bypass path output.
// R14 - Internal registers stay readable by a host during operation.
// R15 - Dual-path mode closes both power paths together.
// R16 - Level selects are one-hot; none asserted means 5 V.
// R17 - After accepting, set selects, wait settling, then signal power ready.
// R18 - Buttons are debounced and act once per press.
`timescale 1ns/1ps
`include "svsel_consts.svh"
module svsel_top
    import svsel_pkg::*;
#(
    parameter int DEBOUNCE_CYC = (`SVSEL_DEBOUNCE_TIME_NS + `SVSEL_CLK_PERIOD_NS - 1) / `SVSEL_CLK_PERIOD_NS,
    parameter int SETTLE_CYC   = (`SVSEL_SETTLE_TIME_NS + `SVSEL_CLK_PERIOD_NS - 1) / `SVSEL_CLK_PERIOD_NS
)(
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] boot_src_in,
    input  wire logic [1:0] strap_input_a_in,
    input  wire logic [1:0] strap_input_b_in,
    input  wire logic       flash_valid_in,
    input  wire logic [7:0] flash_data_in,
    input  wire logic       flash_last_in,
    output logic            flash_req_out,
    input  wire logic       ext_img_valid_in,
    input  wire logic [7:0] ext_img_data_in,
    input  wire logic       ext_img_last_in,
    output logic            ext_img_ready_out,
    output logic            boot_done_out,
    output logic [3:0]      boot_cfg_out,
    input  wire logic       btn_5v_in,
    input  wire logic       btn_9v_in,
    input  wire logic       btn_15v_in,
    input  wire logic       btn_20v_in,
    output logic [3:0]      caps_mask_out,
    output logic            src_caps_send_out,
    input  wire logic       request_valid_in,
    input  wire logic [1:0] request_level_in,
    output logic            request_accept_out,
    output logic            request_reject_out,
    output logic            ps_rdy_send_out,
    output logic            level_select_9v_out,
    output logic            level_select_15v_out,
    output logic            level_select_20v_out,
    output logic            bypass_en_out,
    input  wire logic       dual_path_en_in,
    output logic            path_a_close_out,
    output logic            path_b_close_out,
    input  wire logic       bc_en_in,
    input  wire logic       bc_dp_in,
    output logic            bc_dp_out,
    output logic            bc_dp_oe_out,
    input  wire logic       bc_dm_in,
    output logic            bc_dm_out,
    output logic            bc_dm_oe_out,
    input  wire logic [2:0] rb_addr_in,
    output logic [7:0]      rb_data_out
);
    localparam int SW = $clog2(SETTLE_CYC + 1);

    svsel_btn_if btn_if ();

    // Button order 5, 9, 15, 20 V; 9/15/20 V come from general inputs 1, 2, 5
    assign btn_if.raw = {btn_20v_in, btn_15v_in, btn_9v_in, btn_5v_in}; // R7

    svsel_debounce #(
        .CNT_MAX (DEBOUNCE_CYC)
    ) u_debounce (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .btn         (btn_if.deb)
    );

    // Boot sequencing state
    svsel_boot_t boot_q;
    svsel_boot_t boot_d;
    logic [1:0]  boot_src_q;
    logic [1:0]  boot_src_d;
    logic [3:0]  boot_cfg_q;
    logic [3:0]  boot_cfg_d;
    logic [7:0]  img_sum_q;
    logic [7:0]  img_sum_d;
    logic [7:0]  img_len_q;
    logic [7:0]  img_len_d;

    always_comb
    begin
        boot_d     = boot_q;
        boot_src_d = boot_src_q;
        boot_cfg_d = boot_cfg_q;
        img_sum_d  = img_sum_q;
        img_len_d  = img_len_q;
        case (boot_q)
            SVSEL_BOOT_PICK:
            begin
                boot_src_d = boot_src_in;
                case (boot_src_in)
                    `SVSEL_BOOT_STRAP: boot_d = SVSEL_BOOT_LOAD_STRAP;
                    `SVSEL_BOOT_EXT:   boot_d = SVSEL_BOOT_LOAD_EXT;
                    default:           boot_d = SVSEL_BOOT_LOAD_FLASH;
                endcase
            end
            SVSEL_BOOT_LOAD_FLASH:
            begin
                if (flash_valid_in) // R10
                begin
                    img_sum_d = img_sum_q + flash_data_in;
                    img_len_d = img_len_q + 8'h01;
                    if (flash_last_in)
                    begin
                        boot_d = SVSEL_BOOT_RUN;
                    end
                end
            end
            SVSEL_BOOT_LOAD_STRAP:
            begin
                boot_cfg_d = {strap_input_b_in, strap_input_a_in}; // R11
                boot_d     = SVSEL_BOOT_RUN;
            end
            SVSEL_BOOT_LOAD_EXT:
            begin
                if (ext_img_valid_in) // R12
                begin
                    img_sum_d = img_sum_q + ext_img_data_in;
                    img_len_d = img_len_q + 8'h01;
                    if (ext_img_last_in)
                    begin
                        boot_d = SVSEL_BOOT_RUN;
                    end
                end
            end
            SVSEL_BOOT_RUN:
            begin
                boot_d = SVSEL_BOOT_RUN;
            end
            default:
            begin
                boot_d = SVSEL_BOOT_PICK;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            boot_q     <= SVSEL_BOOT_PICK;
            boot_src_q <= `SVSEL_BOOT_FLASH;
            boot_cfg_q <= 4'h0;
            img_sum_q  <= 8'h00;
            img_len_q  <= 8'h00;
        end
        else
        begin
            boot_q     <= boot_d;
            boot_src_q <= boot_src_d;
            boot_cfg_q <= boot_cfg_d;
            img_sum_q  <= img_sum_d;
            img_len_q  <= img_len_d;
        end
    end

    assign flash_req_out     = (boot_q == SVSEL_BOOT_LOAD_FLASH); // R10
    assign ext_img_ready_out = (boot_q == SVSEL_BOOT_LOAD_EXT); // R12
    assign boot_done_out     = (boot_q == SVSEL_BOOT_RUN);
    assign boot_cfg_out      = boot_cfg_q;

    // Capability list and contract state
    logic [3:0]   caps_q;
    logic [3:0]   caps_d;
    logic         caps_send_q;
    logic         caps_send_d;
    svsel_ct_t    ct_q;
    svsel_ct_t    ct_d;
    logic [SW-1:0] settle_q;
    logic [SW-1:0] settle_d;
    svsel_level_t pend_q;
    svsel_level_t pend_d;
    svsel_level_t contract_q;
    svsel_level_t contract_d;
    logic [2:0]   sel_q;
    logic [2:0]   sel_d;
    logic         acc_q;
    logic         acc_d;
    logic         rej_q;
    logic         rej_d;
    logic         rdy_q;
    logic         rdy_d;
    logic         bypass_q;
    logic         bypass_d;
    logic [3:0]   new_caps;
    logic [1:0]   caps_top;
    logic         req_ok;

    always_comb
    begin
        new_caps = caps_q;
        if (btn_if.press[3])
        begin
            new_caps = 4'hF; // R4
        end
        else if (btn_if.press[2])
        begin
            new_caps = 4'h7; // R3
        end
        else if (btn_if.press[1])
        begin
            new_caps = 4'h3; // R2
        end
        else if (btn_if.press[0])
        begin
            new_caps = `SVSEL_CAPS_RESET; // R6
        end
        caps_top = new_caps[3] ? 2'h3 : new_caps[2] ? 2'h2 : new_caps[1] ? 2'h1 : 2'h0;
        req_ok   = (request_level_in <= caps_top) && (boot_q == SVSEL_BOOT_RUN);
    end

    always_comb
    begin
        caps_d      = caps_q;
        caps_send_d = 1'b0;
        ct_d        = ct_q;
        settle_d    = settle_q;
        pend_d      = pend_q;
        contract_d  = contract_q;
        sel_d       = sel_q;
        acc_d       = 1'b0;
        rej_d       = 1'b0;
        rdy_d       = 1'b0;
        if (boot_q == SVSEL_BOOT_RUN && new_caps != caps_q)
        begin
            caps_d      = new_caps;
            caps_send_d = 1'b1; // R5
            if (contract_q > svsel_level_t'(caps_top))
            begin
                contract_d = SVSEL_LV5;
                sel_d      = 3'h0;
                ct_d       = SVSEL_CT_IDLE;
            end
        end
        case (ct_q)
            SVSEL_CT_IDLE:
            begin
                if (request_valid_in && !caps_send_d)
                begin
                    if (req_ok)
                    begin
                        acc_d    = 1'b1;
                        pend_d   = svsel_level_t'(request_level_in);
                        sel_d    = (request_level_in == 2'h0) ? 3'h0 : 3'(3'h1 << (request_level_in - 2'h1)); // R16
                        settle_d = '0;
                        ct_d     = SVSEL_CT_SETTLE; // R17
                    end
                    else
                    begin
                        rej_d = 1'b1;
                    end
                end
            end
            SVSEL_CT_SETTLE:
            begin
                if (!caps_send_d)
                begin
                    if (settle_q == SW'(SETTLE_CYC - 1))
                    begin
                        rdy_d      = 1'b1; // R17
                        contract_d = pend_q;
                        ct_d       = SVSEL_CT_IDLE;
                    end
                    else
                    begin
                        settle_d = settle_q + SW'(1);
                    end
                end
            end
            default:
            begin
                ct_d = SVSEL_CT_IDLE;
            end
        endcase
        bypass_d = (contract_d == SVSEL_LV20) && (ct_d == SVSEL_CT_IDLE); // R13
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            caps_q      <= `SVSEL_CAPS_RESET; // R1
            caps_send_q <= 1'b0;
            ct_q        <= SVSEL_CT_IDLE;
            settle_q    <= '0;
            pend_q      <= SVSEL_LV5;
            contract_q  <= SVSEL_LV5;
            sel_q       <= 3'h0;
            acc_q       <= 1'b0;
            rej_q       <= 1'b0;
            rdy_q       <= 1'b0;
            bypass_q    <= 1'b0;
        end
        else
        begin
            caps_q      <= caps_d;
            caps_send_q <= caps_send_d;
            ct_q        <= ct_d;
            settle_q    <= settle_d;
            pend_q      <= pend_d;
            contract_q  <= contract_d;
            sel_q       <= sel_d;
            acc_q       <= acc_d;
            rej_q       <= rej_d;
            rdy_q       <= rdy_d;
            bypass_q    <= bypass_d;
        end
    end

    assign caps_mask_out        = caps_q;
    assign src_caps_send_out    = caps_send_q;
    assign request_accept_out   = acc_q;
    assign request_reject_out   = rej_q;
    assign ps_rdy_send_out      = rdy_q;
    assign level_select_9v_out  = sel_q[0]; // R8
    assign level_select_15v_out = sel_q[1]; // R8
    assign level_select_20v_out = sel_q[2]; // R8
    assign bypass_en_out        = bypass_q;

    // Both paths follow the dual-path enable together
    logic dual_q;
    logic dual_d;

    always_comb
    begin
        dual_d = dual_path_en_in && (boot_q == SVSEL_BOOT_RUN); // R15
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            dual_q <= 1'b0;
        end
        else
        begin
            dual_q <= dual_d;
        end
    end

    assign path_a_close_out = dual_q; // R15
    assign path_b_close_out = dual_q; // R15

    // Charger advertisement: D- echoes D+ to emulate the shorted data pair
    logic bc_q;
    logic bc_d;

    always_comb
    begin
        bc_d = bc_en_in && bc_dp_in; // R9
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            bc_q <= 1'b0;
        end
        else
        begin
            bc_q <= bc_d;
        end
    end

    assign bc_dp_out    = 1'b0;
    assign bc_dp_oe_out = 1'b0;
    assign bc_dm_out    = bc_q; // R9
    assign bc_dm_oe_out = bc_en_in; // R9

    // Register readback, live in every state
    logic [7:0] rb_q;
    logic [7:0] rb_d;

    always_comb
    begin
        case (rb_addr_in) // R14
            `SVSEL_RB_CAPS:     rb_d = {4'h0, caps_q};
            `SVSEL_RB_CONTRACT: rb_d = {5'h00, ct_q == SVSEL_CT_SETTLE, contract_q};
            `SVSEL_RB_SELECT:   rb_d = {3'h0, bc_dm_in, bypass_q, sel_q};
            `SVSEL_RB_BOOT:     rb_d = {1'b0, boot_q == SVSEL_BOOT_RUN, boot_src_q, boot_cfg_q};
            `SVSEL_RB_IMG_SUM:  rb_d = img_sum_q;
            `SVSEL_RB_IMG_LEN:  rb_d = img_len_q;
            default:            rb_d = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rb_q <= 8'h00;
        end
        else
        begin
            rb_q <= rb_d;
        end
    end

    assign rb_data_out = rb_q;
endmodule

// file: design/svsel_consts.svh
// Constants for the source voltage selector: timing, boot source codes, readback map.
// Assumes a 125 MHz core clock; counts are derived from these times inside the top module.
`ifndef SVSEL_CONSTS_SVH
`define SVSEL_CONSTS_SVH

`define SVSEL_CLK_PERIOD_NS     8
`define SVSEL_DEBOUNCE_TIME_NS  10000000
`define SVSEL_SETTLE_TIME_NS    1000000

`define SVSEL_BOOT_FLASH        2'h0
`define SVSEL_BOOT_STRAP        2'h1
`define SVSEL_BOOT_EXT          2'h2

`define SVSEL_RB_CAPS           3'h0
`define SVSEL_RB_CONTRACT       3'h1
`define SVSEL_RB_SELECT         3'h2
`define SVSEL_RB_BOOT           3'h3
`define SVSEL_RB_IMG_SUM        3'h4
`define SVSEL_RB_IMG_LEN        3'h5

`define SVSEL_CAPS_RESET        4'h1
`define SVSEL_BTN_COUNT         4

`endif

// file: design/svsel_pkg.sv
// Types shared by the source voltage selector modules.
// Assumes nothing outside itself.
package svsel_pkg;
    typedef enum logic [1:0] {SVSEL_LV5, SVSEL_LV9, SVSEL_LV15, SVSEL_LV20} svsel_level_t;
    typedef enum {SVSEL_BOOT_PICK, SVSEL_BOOT_LOAD_FLASH, SVSEL_BOOT_LOAD_STRAP,
                  SVSEL_BOOT_LOAD_EXT, SVSEL_BOOT_RUN} svsel_boot_t;
    typedef enum {SVSEL_CT_IDLE, SVSEL_CT_SETTLE} svsel_ct_t;
endpackage

// file: design/svsel_btn_if.sv
// Interface carrying raw button levels to the debouncer and press pulses back.
// Bit order: 0 = 5 V, 1 = 9 V, 2 = 15 V, 3 = 20 V button.
`timescale 1ns/1ps
interface svsel_btn_if;
    logic [3:0] raw;
    logic [3:0] press;
    modport ctrl (output raw, input press);
    modport deb  (input raw, output press);
endinterface

// file: design/svsel_debounce.sv
// Debouncer for the selection buttons, one counter per button.
// Assumes active-high button levels synchronous to the core clock.
`timescale 1ns/1ps
`include "svsel_consts.svh"
module svsel_debounce
    import svsel_pkg::*;
#(
    parameter int CNT_MAX = 1250000
)(
    input  wire logic   core_clk_in,
    input  wire logic   rst_n_in,
    svsel_btn_if.deb    btn
);
    localparam int CW = $clog2(CNT_MAX + 1);

    genvar gi;
    generate
        for (gi = 0; gi < `SVSEL_BTN_COUNT; gi++)
        begin : g_btn
            logic [CW-1:0] cnt_q;
            logic [CW-1:0] cnt_d;
            logic          stable_q;
            logic          stable_d;
            logic          press_q;
            logic          press_d;

            // Level must hold CNT_MAX cycles; one pulse per debounced press edge
            always_comb
            begin
                cnt_d    = '0;
                stable_d = stable_q;
                press_d  = 1'b0;
                if (btn.raw[gi] != stable_q)
                begin
                    if (cnt_q == CW'(CNT_MAX - 1)) // R18
                    begin
                        stable_d = btn.raw[gi];
                        press_d  = btn.raw[gi]; // R18
                    end
                    else
                    begin
                        cnt_d = cnt_q + CW'(1);
                    end
                end
            end

            always_ff @(posedge core_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    cnt_q    <= '0;
                    stable_q <= 1'b0;
                    press_q  <= 1'b0;
                end
                else
                begin
                    cnt_q    <= cnt_d;
                    stable_q <= stable_d;
                    press_q  <= press_d;
                end
            end

            assign btn.press[gi] = press_q;
        end
    endgenerate
endmodule

// file: tb/svsel_checker.sv
// Concurrent checks on the source voltage selector top ports.
// Bound into svsel_top; the settling count is handed on from the top.
`timescale 1ns/1ps
module svsel_checker
    import svsel_pkg::*;
#(
    parameter int SETTLE_CYC = 5
)(
    input wire logic       core_clk_in,
    input wire logic       rst_n_in,
    input wire logic       flash_req_out,
    input wire logic       boot_done_out,
    input wire logic [3:0] caps_mask_out,
    input wire logic       src_caps_send_out,
    input wire logic       request_valid_in,
    input wire logic [1:0] request_level_in,
    input wire logic       request_accept_out,
    input wire logic       ps_rdy_send_out,
    input wire logic       level_select_9v_out,
    input wire logic       level_select_15v_out,
    input wire logic       level_select_20v_out,
    input wire logic       bypass_en_out,
    input wire logic       dual_path_en_in,
    input wire logic       path_a_close_out,
    input wire logic       path_b_close_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic [2:0] sel;
    assign sel = {level_select_20v_out, level_select_15v_out, level_select_9v_out};

    sequence s_taken;
        request_valid_in ##1 request_accept_out;
    endsequence
    sequence s_settle;
        !ps_rdy_send_out ##SETTLE_CYC ps_rdy_send_out;
    endsequence

    AST_RESET_CAPS: assert property ($rose(rst_n_in) |-> caps_mask_out == 4'h1 && !boot_done_out)
        else $error("Capability list not 5 V only after reset");
    AST_CAPS_SHAPE: assert property (caps_mask_out inside {4'h1, 4'h3, 4'h7, 4'hf})
        else $error("Capability list has an illegal shape");
    AST_CAPS_SEND: assert property (src_caps_send_out == $changed(caps_mask_out))
        else $error("Capability message pulse does not match a list change");
    AST_SEL_ONEHOT: assert property ($onehot0(sel))
        else $error("Level selects not one-hot");
    AST_ACCEPT_SEL: assert property (s_taken |-> sel == (3'h4 >> (2'h3 - $past(request_level_in))))
        else $error("Level selects do not match accepted request");
    AST_PS_RDY: assert property (request_accept_out |-> s_settle)
        else $error("Power ready not sent after settling time");
    AST_BYPASS_RISE: assert property ($rose(bypass_en_out) |-> ps_rdy_send_out && level_select_20v_out)
        else $error("Bypass enabled without a settled 20 V contract");
    AST_DUAL: assert property (boot_done_out && dual_path_en_in |=> path_a_close_out && path_b_close_out)
        else $error("Dual path mode did not close both paths");
    AST_PATHS_TOGETHER: assert property (path_a_close_out == path_b_close_out)
        else $error("Power paths switched apart");
    AST_FLASH_IDLE: assert property (boot_done_out |-> !flash_req_out)
        else $error("Flash accessed after boot");
endmodule

bind svsel_top svsel_checker #(.SETTLE_CYC(SETTLE_CYC)) i_svsel_checker (.*);

// file: tb/svsel_sink_model.sv
// Sink model: answers each capability message with a request for the top level.
// Assumes the selector's message pulses are one cycle wide.
`timescale 1ns/1ps
module svsel_sink_model (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [3:0] caps_mask_in,
    input  wire logic       src_caps_send_in,
    input  wire logic       ps_rdy_send_in,
    input  wire logic       request_reject_in,
    input  wire logic       cmd_valid_in,
    input  wire logic [1:0] cmd_level_in,
    output logic            request_valid_out,
    output logic [1:0]      request_level_out
);
    logic       pend_q;
    logic       busy_q;
    logic [1:0] lvl_q;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            {pend_q, busy_q, lvl_q, request_valid_out, request_level_out} <= '0;
        else
        begin
            request_valid_out <= 1'b0;
            if (request_valid_out)
                request_level_out <= ~request_level_out;
            if (cmd_valid_in)
            begin
                pend_q <= 1'b1;
                lvl_q  <= cmd_level_in;
            end
            else if (src_caps_send_in)
            begin
                pend_q <= 1'b1;
                lvl_q  <= caps_mask_in[3] ? 2'h3 : caps_mask_in[2] ? 2'h2 : {1'b0, caps_mask_in[1]};
            end
            if (pend_q && !busy_q && !request_valid_out)
            begin
                request_valid_out <= 1'b1;
                request_level_out <= lvl_q;
                pend_q            <= 1'b0;
                busy_q            <= 1'b1;
            end
            if (request_reject_in || ps_rdy_send_in)
                busy_q <= 1'b0;
        end
    end
endmodule

// file: tb/svsel_top_test.sv
// Testbench for the source voltage selector with a sink model on the request side.
// Assumes short debounce and settling counts set at the instance.
`timescale 1ns/1ps
module svsel_top_test;
    logic       core_clk_in, rst_n_in, img_valid, img_last, cmd_valid;
    logic       flash_req_out, ext_img_ready_out, boot_done_out, src_caps_send_out;
    logic       request_valid_in, request_accept_out, request_reject_out, ps_rdy_send_out;
    logic       level_select_9v_out, level_select_15v_out, level_select_20v_out, bypass_en_out;
    logic       dual_path_en_in, path_a_close_out, path_b_close_out, bc_en_in, bc_dp_in;
    logic       bc_dp_out, bc_dp_oe_out, bc_dm_in, bc_dm_out, bc_dm_oe_out;
    logic [1:0] boot_src_in, strap_input_a_in, strap_input_b_in, request_level_in, cmd_level;
    logic [2:0] rb_addr_in;
    logic [3:0] boot_cfg_out, caps_mask_out, btn_raw;
    logic [7:0] img_data, rb_data_out;
    int         fails, cmp_count, n_send, n_rej, n_flash;

    // D- wire with pull-down
    assign bc_dm_in = bc_dm_oe_out ? bc_dm_out : 1'b0;

    svsel_top #(.DEBOUNCE_CYC(4), .SETTLE_CYC(5)) i_svsel_top (
        .*, .flash_valid_in(img_valid), .flash_data_in(img_data), .flash_last_in(img_last),
        .ext_img_valid_in(img_valid), .ext_img_data_in(img_data), .ext_img_last_in(img_last),
        .btn_5v_in(btn_raw[0]), .btn_9v_in(btn_raw[1]), .btn_15v_in(btn_raw[2]), .btn_20v_in(btn_raw[3])
    );

    svsel_sink_model i_svsel_sink_model (
        .core_clk_in, .rst_n_in, .caps_mask_in(caps_mask_out), .src_caps_send_in(src_caps_send_out),
        .ps_rdy_send_in(ps_rdy_send_out), .request_reject_in(request_reject_out), .cmd_valid_in(cmd_valid),
        .cmd_level_in(cmd_level), .request_valid_out(request_valid_in), .request_level_out(request_level_in)
    );

    initial
    begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in)
    begin
        n_send  += int'(src_caps_send_out === 1'b1);
        n_rej   += int'(request_reject_out === 1'b1);
        n_flash += int'(flash_req_out === 1'b1);
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] src);
        @(posedge core_clk_in);
        rst_n_in    <= 1'b0;
        boot_src_in <= src;
        repeat (12) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
    endtask

    task automatic rb_check(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        rb_addr_in <= a;
        repeat (2) @(posedge core_clk_in);
        #1;
        check(rb_data_out, exp);
    endtask

    task automatic load_img(input bit ext, input int n, input logic [7:0] base);
        logic [7:0] sum;
        int         k;
        sum = 8'h00;
        k   = 0;
        while ((ext ? ext_img_ready_out : flash_req_out) !== 1'b1 && k < 50)
        begin
            @(posedge core_clk_in);
            k++;
        end
        for (int i = 0; i < n; i++)
        begin
            img_valid <= 1'b1;
            img_data  <= base + 8'(i);
            img_last  <= (i == n - 1);
            sum       += base + 8'(i);
            @(posedge core_clk_in);
        end
        img_valid <= 1'b0;
        img_last  <= 1'b0;
        img_data  <= ~img_data;
        repeat (3) @(posedge core_clk_in);
        #1;
        check(8'(boot_done_out), 8'h01);
        rb_check(3'h4, sum);
        rb_check(3'h5, 8'(n));
    endtask

    task automatic t_buttons;
        int seq [5] = '{2, 3, 0, 1, 1};
        int b;
        int s0;
        foreach (seq[j])
        begin
            b  = seq[j];
            s0 = n_send;
            @(posedge core_clk_in);
            btn_raw <= 4'h1 << b;
            repeat (10) @(posedge core_clk_in);
            btn_raw <= 4'h0;
            repeat (30) @(posedge core_clk_in);
            #1;
            check(8'(caps_mask_out), (8'h02 << b) - 8'h01);
            check(8'(n_send - s0), (j == 4) ? 8'h00 : 8'h01);
            check(8'({level_select_20v_out, level_select_15v_out, level_select_9v_out}), 8'h04 >> (3 - b));
            check(8'(bypass_en_out), 8'(b == 3));
            rb_check(3'h0, (8'h02 << b) - 8'h01);
        end
    endtask

    task automatic t_reject;
        int r0;
        r0 = n_rej;
        @(posedge core_clk_in);
        cmd_valid <= 1'b1;
        cmd_level <= 2'h3;
        @(posedge core_clk_in);
        cmd_valid <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        #1;
        check(8'(n_rej - r0), 8'h01);
        check(8'({level_select_20v_out, level_select_15v_out, level_select_9v_out}), 8'h01);
    endtask

    task automatic t_dual_bc;
        @(posedge core_clk_in);
        dual_path_en_in <= 1'b1;
        bc_en_in        <= 1'b1;
        bc_dp_in        <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        #1;
        check(8'({path_a_close_out, path_b_close_out}), 8'h03);
        check(8'({bc_dm_out, bc_dm_oe_out, bc_dp_oe_out, bc_dp_out}), 8'h0C);
        @(posedge core_clk_in);
        dual_path_en_in <= 1'b0;
    endtask

    task automatic t_strap_ext;
        int f0;
        f0 = n_flash;
        strap_input_a_in <= 2'h2;
        strap_input_b_in <= 2'h1;
        do_reset(2'h1);
        repeat (6) @(posedge core_clk_in);
        #1;
        check(8'(boot_done_out), 8'h01);
        check(8'(boot_cfg_out), 8'h06);
        check(8'(caps_mask_out), 8'h01);
        do_reset(2'h2);
        load_img(1'b1, 2, 8'h40);
        check(8'(n_flash - f0), 8'h00);
    endtask

    initial
    begin
        {rst_n_in, img_valid, img_last, cmd_valid, dual_path_en_in, bc_en_in, bc_dp_in} = '0;
        {boot_src_in, strap_input_a_in, strap_input_b_in, cmd_level, rb_addr_in, btn_raw, img_data} = '0;
        do_reset(2'h0);
        load_img(1'b0, 3, 8'h11);
        check(8'(caps_mask_out), 8'h01);
        t_buttons;
        t_reject;
        t_dual_bc;
        t_strap_ext;
        end_sim;
    end

    initial
    begin
        #100000;
        fails++;
        end_sim;
    end
endmodule
